// >>> verilog/ctg_pkg.sv
package ctg_pkg;
    localparam logic [3:0] CTG_ADDR_LINK = 4'h0;
    localparam logic [3:0] CTG_ADDR_REF = 4'h4;
    localparam logic [7:0] CTG_LINK_MASK = 8'h1B;
    localparam logic [7:0] CTG_REF_MASK = 8'hBF;
    localparam logic [7:0] CTG_LINK_RESET = 8'h02;
    localparam logic [7:0] CTG_REF_RESET = 8'h00;
    localparam int CTG_BIT_SYNC = 0;
    localparam int CTG_BIT_GSS = 1;
    localparam int CTG_BIT_HYS = 3;
    localparam int CTG_BIT_ACS = 4;
    localparam int CTG_BIT_DIV = 7;
    localparam int CTG_BIT_RANGE = 5;
    localparam int CTG_BIT_FIXED = 4;
    localparam logic [1:0] CTG_PRESC_RESET = 2'h0;

    typedef enum logic [2:0] {
        CTG_REF_GROUND = 3'b001,
        CTG_REF_FIXED = 3'b010,
        CTG_REF_LADDER = 3'b100
    } ctg_ref_e;

    typedef struct packed {
        logic power;
        logic low_range;
        logic [3:0] level;
    } ctg_ladder_s;
endpackage

// >>> verilog/ctg_link.sv
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module ctg_link (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_comp_out,
    input wire logic i_external_gate_pin,
    input wire logic i_timer_on,
    input wire logic i_gate_enable,
    input wire logic [1:0] i_prescale_sel,
    input wire logic i_high_freq_internal_oscillator,
    output logic o_timer_clk,
    output logic o_timer_gate,
    output logic o_hysteresis_enable,
    output ctg_pkg::ctg_ladder_s o_ladder,
    output logic o_fixed_reference_enable,
    output ctg_pkg::ctg_ref_e o_ref_sel
);
    import ctg_pkg::*;

    logic [7:0] comparator_link_control;
    logic [7:0] reference_control;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] div4;
    logic [2:0] presc;
    logic comp_meta, comp_sync2, ext_meta, ext_sync2, osc_meta, osc_sync2;
    logic comp_latched;

    // Register address match, shared by write strobes and read select
    function automatic logic addr_hit(input logic [3:0] adr, input logic [3:0] target);
        return (adr == target);
    endfunction

    wire bus_req = i_wb_cyc & i_wb_stb & ~ack;
    // Writes land on the edge where the master sees ack high
    wire bus_take = i_wb_cyc & i_wb_stb & ack;
    wire wr_link = bus_take & i_wb_we & i_wb_sel[0] & addr_hit(i_wb_adr, CTG_ADDR_LINK);
    wire wr_ref = bus_take & i_wb_we & i_wb_sel[0] & addr_hit(i_wb_adr, CTG_ADDR_REF);
    wire [7:0] rd_byte = addr_hit(i_wb_adr, CTG_ADDR_LINK) ? comparator_link_control :
                         addr_hit(i_wb_adr, CTG_ADDR_REF) ? reference_control : 8'h00;
    wire sync_en = comparator_link_control[CTG_BIT_SYNC];
    wire gate_pin_sel = comparator_link_control[CTG_BIT_GSS];
    // Alt clock as a level on i_clk tops out at half the system rate
    wire base_clk = comparator_link_control[CTG_BIT_ACS] ? presc[0] : div4[1];
    // Prescaled clock as a level; the timer side counts on its rising edge
    wire presc_clk = (i_prescale_sel == 2'h0) ? base_clk : presc[i_prescale_sel - 2'h1];
    wire comp_path = sync_en ? comp_latched : comp_sync2;
    wire gate_src = gate_pin_sel ? ext_sync2 : comp_path;
    wire div_on = reference_control[CTG_BIT_DIV];
    wire fixed_on = reference_control[CTG_BIT_FIXED] | osc_sync2;

    // Divide-by-four toggles at the system rate
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            div4 <= 2'h0;
        end else begin
            div4 <= div4 + 2'h1;
        end
    end

    // Ripple of the selected base clock to make prescale taps
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            presc <= 3'h0;
        end else if (comparator_link_control[CTG_BIT_ACS] || div4 == 2'h3) begin
            presc <= presc + 3'h1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            comp_meta <= 1'b0;
            comp_sync2 <= 1'b0;
            ext_meta <= 1'b0;
            ext_sync2 <= 1'b0;
            osc_meta <= 1'b0;
            osc_sync2 <= 1'b0;
        end else begin
            comp_meta <= i_comp_out;
            comp_sync2 <= comp_meta;
            ext_meta <= i_external_gate_pin;
            ext_sync2 <= ext_meta;
            osc_meta <= i_high_freq_internal_oscillator;
            osc_sync2 <= osc_meta;
        end
    end

    // Latch on the falling edge of the prescaled timer clock; holds otherwise
    logic presc_clk_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            presc_clk_q <= 1'b0;
            comp_latched <= 1'b0;
        end else begin
            presc_clk_q <= presc_clk;
            if (presc_clk_q && !presc_clk) begin
                comp_latched <= comp_sync2;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            comparator_link_control <= CTG_LINK_RESET;
            reference_control <= CTG_REF_RESET;
        end else begin
            if (wr_link) begin
                comparator_link_control <= i_wb_dat[7:0] & CTG_LINK_MASK;
            end
            if (wr_ref) begin
                reference_control <= i_wb_dat[7:0] & CTG_REF_MASK;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            ack <= bus_req;
            if (bus_req && !i_wb_we) begin
                rdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_timer_gate <= 1'b0;
            o_timer_clk <= 1'b0;
        end else begin
            o_timer_gate <= (i_timer_on & i_gate_enable) ? gate_src : 1'b1;
            o_timer_clk <= presc_clk;
        end
    end

    assign o_wb_ack = ack;
    assign o_wb_dat = rdata;
    assign o_hysteresis_enable = comparator_link_control[CTG_BIT_HYS];
    assign o_ladder.power = div_on;
    assign o_ladder.low_range = reference_control[CTG_BIT_RANGE];
    assign o_ladder.level = reference_control[3:0];
    assign o_fixed_reference_enable = fixed_on;
    assign o_ref_sel = div_on ? CTG_REF_LADDER : (fixed_on ? CTG_REF_FIXED : CTG_REF_GROUND);

    chk_latch_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        !(presc_clk_q && !presc_clk) |=> $stable(comp_latched)) else $error("latch moved off edge");
    chk_gate_src_pin: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_timer_on && i_gate_enable && gate_pin_sel) |=> o_timer_gate == $past(ext_sync2))
        else $error("pin gate wrong");
    chk_gate_off: assert property (@(posedge i_clk) disable iff (i_rst)
        !(i_timer_on && i_gate_enable) |=> o_timer_gate) else $error("gate active when off");
    chk_sync_bypass: assert property (@(posedge i_clk) disable iff (i_rst)
        (!sync_en && !gate_pin_sel && i_timer_on && i_gate_enable) |=> o_timer_gate == $past(comp_sync2))
        else $error("async path wrong");
    chk_unimpl_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        (comparator_link_control & ~CTG_LINK_MASK) == 8'h00) else $error("unimplemented bit set");
    chk_ref_ground: assert property (@(posedge i_clk) disable iff (i_rst)
        (!div_on && !fixed_on) |-> o_ref_sel == CTG_REF_GROUND) else $error("no clamp");
    chk_ref_ladder: assert property (@(posedge i_clk) disable iff (i_rst)
        div_on |-> (o_ref_sel == CTG_REF_LADDER && o_ladder.power)) else $error("ladder not chosen");
    chk_fixed_osc: assert property (@(posedge i_clk) disable iff (i_rst)
        osc_sync2 |-> o_fixed_reference_enable) else $error("fixed not forced");
    chk_ack_once: assert property (@(posedge i_clk) disable iff (i_rst)
        o_wb_ack |=> !o_wb_ack) else $error("ack held");

    chk_gate_src_comp: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_timer_on && i_gate_enable && !gate_pin_sel)
        |=> o_timer_gate == $past(comp_path))
        else $error("comparator gate wrong");

    chk_ext_sync_stage: assert property (@(posedge i_clk) disable iff (i_rst)
        1'b1
        |=> ext_sync2 == $past(ext_meta))
        else $error("pin sync stage wrong");

    chk_gate_latched: assert property (@(posedge i_clk) disable iff (i_rst)
        (sync_en && !gate_pin_sel && i_timer_on && i_gate_enable)
        |=> o_timer_gate == $past(comp_latched))
        else $error("latched path wrong");

    chk_latch_on_fall: assert property (@(posedge i_clk) disable iff (i_rst)
        (presc_clk_q && !presc_clk)
        |=> comp_latched == $past(comp_sync2))
        else $error("latch missed falling edge");

    chk_comp_sync_stage: assert property (@(posedge i_clk) disable iff (i_rst)
        1'b1
        |=> comp_sync2 == $past(comp_meta))
        else $error("comparator sync stage wrong");

    chk_latch_rise_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        (!presc_clk_q && presc_clk)
        |=> $stable(comp_latched))
        else $error("latch moved on rising edge");

    chk_timer_clk_follow: assert property (@(posedge i_clk) disable iff (i_rst)
        1'b1
        |=> o_timer_clk == $past(presc_clk))
        else $error("timer clock not prescaled");

    chk_presc_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        (!comparator_link_control[CTG_BIT_ACS] && div4 != 2'h3)
        |=> $stable(presc))
        else $error("prescaler stepped off tick");

    chk_presc_tap1: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_prescale_sel == 2'h1)
        |-> presc_clk == presc[0])
        else $error("divide by two tap wrong");

    chk_presc_tap2: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_prescale_sel == 2'h2)
        |-> presc_clk == presc[1])
        else $error("divide by four tap wrong");

    chk_presc_tap3: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_prescale_sel == 2'h3)
        |-> presc_clk == presc[2])
        else $error("divide by eight tap wrong");

    chk_presc_div1: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_prescale_sel == 2'h0 && !comparator_link_control[CTG_BIT_ACS])
        |-> presc_clk == div4[1])
        else $error("instruction clock wrong");

    chk_presc_alt0: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_prescale_sel == 2'h0 && comparator_link_control[CTG_BIT_ACS])
        |-> presc_clk == presc[0])
        else $error("alt clock wrong");

    chk_presc_alt_step: assert property (@(posedge i_clk) disable iff (i_rst)
        comparator_link_control[CTG_BIT_ACS]
        |=> presc == $past(presc) + 3'h1)
        else $error("alt clock not stepping");

    chk_div4_step: assert property (@(posedge i_clk) disable iff (i_rst)
        1'b1
        |=> div4 == $past(div4) + 2'h1)
        else $error("divide by four stalled");

    chk_hys_write: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_link
        |=> o_hysteresis_enable == $past(i_wb_dat[CTG_BIT_HYS]))
        else $error("hysteresis not written");

    chk_link_write: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_link
        |=> comparator_link_control == ($past(i_wb_dat[7:0]) & CTG_LINK_MASK))
        else $error("link write wrong");

    chk_link_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        !wr_link
        |=> $stable(comparator_link_control))
        else $error("link changed without write");

    chk_read_data: assert property (@(posedge i_clk) disable iff (i_rst)
        (bus_req && !i_wb_we)
        |=> o_wb_dat[7:0] == $past(rd_byte))
        else $error("read data wrong");

    chk_read_upper: assert property (@(posedge i_clk) disable iff (i_rst)
        1'b1
        |-> o_wb_dat[31:8] == 24'h00_0000)
        else $error("upper read lanes set");

    chk_lane_gate: assert property (@(posedge i_clk) disable iff (i_rst)
        (bus_take && !i_wb_sel[0])
        |=> $stable(comparator_link_control) && $stable(reference_control))
        else $error("write without lane zero");

    chk_ref_write: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_ref
        |=> reference_control == ($past(i_wb_dat[7:0]) & CTG_REF_MASK))
        else $error("reference write wrong");

    chk_ref_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        !wr_ref
        |=> $stable(reference_control))
        else $error("reference changed without write");

    chk_ref_unimpl: assert property (@(posedge i_clk) disable iff (i_rst)
        1'b1
        |-> (reference_control & ~CTG_REF_MASK) == 8'h00)
        else $error("reference spare bit set");

    chk_ladder_level: assert property (@(posedge i_clk) disable iff (i_rst)
        1'b1
        |-> o_ladder.level == reference_control[3:0])
        else $error("ladder level wrong");

    chk_ladder_range: assert property (@(posedge i_clk) disable iff (i_rst)
        1'b1
        |-> o_ladder.low_range == reference_control[CTG_BIT_RANGE])
        else $error("ladder range wrong");

    chk_power_off: assert property (@(posedge i_clk) disable iff (i_rst)
        !div_on
        |-> !o_ladder.power)
        else $error("ladder powered while off");

    chk_fixed_sel: assert property (@(posedge i_clk) disable iff (i_rst)
        (!div_on && fixed_on)
        |-> o_ref_sel == CTG_REF_FIXED)
        else $error("fixed not chosen");

    chk_fixed_bit: assert property (@(posedge i_clk) disable iff (i_rst)
        reference_control[CTG_BIT_FIXED]
        |-> o_fixed_reference_enable)
        else $error("fixed enable ignored");

    chk_osc_sync_stage: assert property (@(posedge i_clk) disable iff (i_rst)
        1'b1
        |=> osc_sync2 == $past(osc_meta))
        else $error("oscillator sync stage wrong");

    chk_ref_onehot: assert property (@(posedge i_clk) disable iff (i_rst)
        1'b1
        |-> $onehot(o_ref_sel))
        else $error("reference select not one-hot");

    chk_ack_after_req: assert property (@(posedge i_clk) disable iff (i_rst)
        bus_req
        |=> o_wb_ack)
        else $error("ack missing");

    chk_no_req_no_ack: assert property (@(posedge i_clk) disable iff (i_rst)
        !bus_req
        |=> !o_wb_ack)
        else $error("ack without request");

    chk_gate_timer_on: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_timer_on && i_gate_enable)
        |=> o_timer_gate == $past(gate_src))
        else $error("gate source not passed");
endmodule
`default_nettype wire

// >>> tb/ctg_timer_model.sv
`timescale 1ns/100ps
`default_nettype none
module ctg_timer_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_timer_clk,
    input wire logic i_gate,
    output logic [15:0] o_count
);
    logic prev_clk;
    // Counts only on a rise of the timer clock, with the gate level of that edge
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            prev_clk <= 1'b0;
            o_count <= 16'h0000;
        end else begin
            prev_clk <= i_timer_clk;
            if (i_timer_clk && !prev_clk && i_gate) begin
                o_count <= o_count + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    import ctg_pkg::*;
    logic i_clk = 0, i_rst = 1, cyc = 0, stb = 0, we = 0, comp = 0, pin = 0, ton = 0, gen = 0, hfo = 0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic [1:0] presc = 2'h0;
    logic ack, tclk, gate, hys, fen;
    logic [7:0] q;
    logic [15:0] cnt, c0;
    ctg_ladder_s lad;
    ctg_ref_e rsel;
    int mismatches = 0, comparisons = 0;
    always #50 i_clk = ~i_clk;
    ctg_link dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_dat(wdat), .i_wb_sel(4'hF), .o_wb_dat(rdat), .o_wb_ack(ack), .i_comp_out(comp),
        .i_external_gate_pin(pin), .i_timer_on(ton), .i_gate_enable(gen), .i_prescale_sel(presc),
        .i_high_freq_internal_oscillator(hfo), .o_timer_clk(tclk), .o_timer_gate(gate),
        .o_hysteresis_enable(hys), .o_ladder(lad), .o_fixed_reference_enable(fen), .o_ref_sel(rsel));
    ctg_timer_model tmr_u (.i_clk(i_clk), .i_rst(i_rst), .i_timer_clk(tclk), .i_gate(gate), .o_count(cnt));
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        do begin
            @(posedge i_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            tally_and_finish();
        end
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic gate_case(input logic [7:0] l, input logic p, input logic c, input logic e);
        wb(1'b1, CTG_ADDR_LINK, l);
        pin <= p;
        comp <= c;
        for (int k = 0; k < 40 && gate !== e; k++) @(posedge i_clk);
        `CHK("gate", e, gate);
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        wb(1'b0, CTG_ADDR_LINK, 8'h00); `CHK("link", 8'h02, q);
        wb(1'b0, CTG_ADDR_REF, 8'h00); `CHK("ref", 8'h00, q);
        `CHK("rsel", CTG_REF_GROUND, rsel);
        wb(1'b1, CTG_ADDR_LINK, 8'hFF); wb(1'b0, CTG_ADDR_LINK, 8'h00); `CHK("link", 8'h1B, q);
        `CHK("hys", 1'b1, hys);
        wb(1'b1, 4'h8, 8'hFF); wb(1'b0, 4'h8, 8'h00); `CHK("unmapped", 8'h00, q);
        wb(1'b1, CTG_ADDR_REF, 8'hFF); wb(1'b0, CTG_ADDR_REF, 8'h00); `CHK("ref", 8'hBF, q);
        `CHK("ladder", 6'h3F, lad);
        `CHK("rsel", CTG_REF_LADDER, rsel);
        wb(1'b1, CTG_ADDR_REF, 8'h10);
        repeat (4) @(posedge i_clk);
        `CHK("rsel", CTG_REF_FIXED, rsel);
        hfo <= 1'b1;
        wb(1'b1, CTG_ADDR_REF, 8'h00);
        repeat (6) @(posedge i_clk);
        `CHK("fen", 1'b1, fen);
        hfo <= 1'b0;
        repeat (6) @(posedge i_clk);
        `CHK("fen", 1'b0, fen);
        `CHK("power", 1'b0, lad.power);
        ton <= 1'b1;
        gen <= 1'b1;
        gate_case(8'h02, 1'b0, 1'b1, 1'b0);
        gate_case(8'h02, 1'b1, 1'b0, 1'b1);
        gate_case(8'h00, 1'b1, 1'b0, 1'b0);
        gate_case(8'h01, 1'b1, 1'b0, 1'b0);
        c0 = cnt;
        repeat (40) @(posedge i_clk);
        `CHK("held", c0, cnt);
        gate_case(8'h01, 1'b0, 1'b1, 1'b1);
        // Prescaled clock rate seen as counts over a fixed window
        for (int p = 0; p < 3; p++) begin
            presc <= p[1:0];
            repeat (40) @(posedge i_clk);
            c0 = cnt;
            repeat (80) @(posedge i_clk);
            `CHK("rate", 16'(20 >> p), 16'(cnt - c0));
        end
        // Alt clock at divide by four runs at the undivided instruction rate
        wb(1'b1, CTG_ADDR_LINK, 8'h11);
        presc <= 2'h2;
        repeat (40) @(posedge i_clk);
        c0 = cnt;
        repeat (80) @(posedge i_clk);
        `CHK("alt_rate", 16'd20, 16'(cnt - c0));
        presc <= 2'h0;
        ton <= 1'b0;
        gate_case(8'h00, 1'b0, 1'b0, 1'b1);
        // Second reset in mid-run restores the link register
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        wb(1'b0, CTG_ADDR_LINK, 8'h00); `CHK("link_rst", 8'h02, q);
        tally_and_finish();
    end
endmodule
`default_nettype wire
